// ==== include/hbd_pkg.sv ====
package hbd_pkg;
  localparam int IOQ_DEPTH = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int FIFO_DEPTH = 32;
  // phase-one request codes
  localparam logic [4:0] RQ_DEFER_REPLY = 5'h00;
  localparam logic [4:0] RQ_MEM_RDINV = 5'h02;
  localparam logic [4:0] RQ_MEM_CODE = 5'h04;
  localparam logic [4:0] RQ_MEM_WB = 5'h05;
  localparam logic [4:0] RQ_MEM_DATA = 5'h06;
  localparam logic [4:0] RQ_MEM_WR = 5'h07;
  localparam logic [4:0] RQ_SPECIAL = 5'h08;
  localparam logic [4:0] RQ_BTM = 5'h09;
  localparam logic [4:0] RQ_IO_RD = 5'h10;
  localparam logic [4:0] RQ_IO_WR = 5'h11;
  // phase-two sub-codes
  localparam logic [4:0] RQB_INTA = 5'h00;
  localparam logic [4:0] RQB_SPEC = 5'h01;
  localparam logic [1:0] SIZE_OK = 2'h0;
  // length field
  localparam logic [1:0] LEN_8 = 2'h0;
  localparam logic [1:0] LEN_16 = 2'h1;
  localparam logic [1:0] LEN_32 = 2'h2;
  // response codes
  localparam logic [2:0] RSP_IDLE = 3'h0;
  localparam logic [2:0] RSP_RETRY = 3'h1;
  localparam logic [2:0] RSP_DEFER = 3'h2;
  localparam logic [2:0] RSP_NODATA = 3'h5;
  localparam logic [2:0] RSP_IWB = 3'h6;
  localparam logic [2:0] RSP_DATA = 3'h7;
  // io config window (config address/data ports)
  localparam logic [15:0] IO_CFG_LO = 16'h0CF8;
  localparam logic [15:0] IO_CFG_HI = 16'h0CFF;

  typedef enum logic [2:0] {
    DST_NONE, DST_DRAM, DST_HUB, DST_CFG, DST_GFX, DST_SPEC
  } dest_t;

  typedef struct packed {
    logic [4:0] request_code_phase_one;
    logic [4:0] request_code_phase_two;
    logic [ADDR_W-1:0] addr;
    logic [7:0] byte_lane_enables;
  } host_req_t;

  typedef struct packed {
    dest_t dest;
    logic is_read;
    logic is_write;
    logic can_retry;
    logic can_defer;
    logic zero_len;
    logic no_data_capture;
    logic [1:0] transfer_length_field;
    logic [ADDR_W-1:0] addr;
    logic [7:0] byte_lane_enables;
  } txn_t;

  typedef struct packed {
    logic [2:0] response_status_code;
    logic [DATA_W-1:0] data;
    logic data_valid;
  } host_rsp_t;
endpackage

// ==== rtl/hbd_fifo.sv ====
`timescale 1ns/1ns
module hbd_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, rp_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wp_q != rp_q;
  assign out_data_o = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wp_q[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // hbd_fifo

// ==== rtl/host_bus_transaction_decoder.sv ====
`timescale 1ns/1ns
module host_bus_transaction_decoder
  import hbd_pkg::*;
#(
  parameter int DEPTH = IOQ_DEPTH,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // request phase
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire host_req_t req_i,
  // address map context
  input wire logic [ADDR_W-1:0] dram_top_i,
  input wire logic [ADDR_W-1:0] gfx_base_i,
  input wire logic [ADDR_W-1:0] gfx_mask_i,
  input wire logic lock_i,
  input wire logic snoop_hitm_i,
  // resource side: hub link busy -> retry, slow target -> defer
  input wire logic hub_busy_i,
  input wire logic defer_en_i,
  // dispatch to targets
  output logic disp_valid_o,
  input wire logic disp_ready_i,
  output txn_t disp_o,
  // read data returned by target
  input wire logic rdata_valid_i,
  output logic rdata_ready_o,
  input wire logic [DATA_W-1:0] rdata_i,
  // deferred completion from the target
  input wire logic defer_done_i,
  output logic defer_reply_o,
  // response phase
  output host_rsp_t rsp_o,
  output logic bad_size_o
);
  initial
  begin
    if (DEPTH != 4)
      $error("in-order queue depth must be 4");
  end

  localparam int PW = $clog2(DEPTH);
  txn_t q_mem [DEPTH];
  logic [PW:0] wp_q, rp_q;
  logic [PW:0] cnt;
  host_rsp_t rsp_q;
  logic defer_reply_q, bad_size_q, defer_pend_q;
  logic buf_valid, buf_ready;
  logic [DATA_W-1:0] buf_data;
  txn_t dec, head;
  logic in_gfx, io_cfg, push, retire, head_data_wait, mem_code;

  assign cnt = wp_q - rp_q;
  assign req_ready_o = cnt != (PW+1)'(DEPTH);
  assign push = req_valid_i && req_ready_o;
  assign head = q_mem[rp_q[PW-1:0]];

  // address decode
  assign in_gfx = (req_i.addr & gfx_mask_i) == gfx_base_i;
  assign io_cfg = req_i.addr[15:0] >= IO_CFG_LO &&
    req_i.addr[15:0] <= IO_CFG_HI;
  // address size only applies to memory codes; special and trace use 01
  assign mem_code = !req_i.request_code_phase_one[4] &&
    req_i.request_code_phase_one[2:0] inside {3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

  always_comb
  begin
    dec = '0;
    dec.addr = req_i.addr;
    dec.byte_lane_enables = req_i.byte_lane_enables;
    dec.transfer_length_field = req_i.request_code_phase_two[1:0];
    dec.zero_len = req_i.request_code_phase_two[1:0] == LEN_8 &&
      req_i.byte_lane_enables == 8'h00;
    unique case (req_i.request_code_phase_one)
      RQ_MEM_RDINV, RQ_MEM_DATA, RQ_MEM_CODE:
      begin
        dec.is_read = 1'b1;
        if (req_i.addr < dram_top_i)
          dec.dest = DST_DRAM;
        else if (in_gfx)
          dec.dest = DST_GFX;
        else
          dec.dest = DST_HUB;
      end
      RQ_MEM_WB:
      begin
        dec.is_write = 1'b1;
        dec.dest = DST_DRAM;
      end
      RQ_MEM_WR:
      begin
        dec.is_write = 1'b1;
        if (req_i.addr < dram_top_i)
          dec.dest = DST_DRAM;
        else if (in_gfx)
          dec.dest = DST_GFX;
        else
          dec.dest = DST_HUB;
      end
      RQ_IO_RD, RQ_IO_WR:
      begin
        dec.is_read = req_i.request_code_phase_one == RQ_IO_RD;
        dec.is_write = !dec.is_read;
        dec.dest = io_cfg ? DST_CFG : DST_HUB;
      end
      RQ_SPECIAL:
      begin
        if (req_i.request_code_phase_two == RQB_INTA)
        begin
          dec.is_read = 1'b1;
          dec.dest = DST_HUB;
        end
        else
          dec.dest = DST_SPEC;
      end
      RQ_BTM:
        dec.no_data_capture = 1'b1;
      default:
        dec.dest = DST_NONE;
    endcase
    // retry: hub reads/writes and locked DRAM reads only
    dec.can_retry = (dec.dest == DST_HUB && (dec.is_read || dec.is_write))
      || (dec.dest == DST_DRAM && dec.is_read && lock_i);
    dec.can_defer = dec.is_read && (dec.dest == DST_HUB ||
      dec.dest == DST_GFX) ||
      (dec.dest inside {DST_HUB, DST_GFX} && dec.is_write &&
      req_i.request_code_phase_one == RQ_IO_WR);
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      q_mem[wp_q[PW-1:0]] <= dec;
  end

  // size fields must be 00; length 11 is reserved
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bad_size_q <= 1'b0;
    else
      bad_size_q <= push && (
        mem_code &&
        req_i.request_code_phase_one[4:3] != SIZE_OK ||
        req_i.request_code_phase_two[4:3] != SIZE_OK ||
        (dec.is_read || dec.is_write) &&
        req_i.request_code_phase_two[1:0] == 2'h3);
  end
  assign bad_size_o = bad_size_q;

  // read data waits in the buffer for its response phase
  hbd_fifo #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_rbuf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(rdata_valid_i),
    .in_ready_o(rdata_ready_o),
    .in_data_i(rdata_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  // head needs data unless it is retried, deferred or data-less
  assign head_data_wait = head.is_read && !head.zero_len &&
    !(head.can_retry && hub_busy_i) && !(head.can_defer && defer_en_i);
  assign disp_valid_o = cnt != '0;
  assign disp_o = head;
  assign retire = disp_valid_o && disp_ready_i &&
    (!head_data_wait || buf_valid);
  assign buf_ready = retire && head_data_wait;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (retire)
        rp_q <= rp_q + 1'b1;
    end
  end

  // response code, one cycle per retired transaction
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rsp_q <= '0;
    else
    begin
      rsp_q <= '0;
      if (retire)
      begin
        if (head.can_retry && hub_busy_i)
          rsp_q.response_status_code <= RSP_RETRY;
        else if (head.can_defer && defer_en_i)
          rsp_q.response_status_code <= RSP_DEFER;
        else if (snoop_hitm_i)
          rsp_q.response_status_code <= RSP_IWB;
        else if (head_data_wait)
        begin
          rsp_q.response_status_code <= RSP_DATA;
          rsp_q.data <= buf_data;
          rsp_q.data_valid <= 1'b1;
        end
        else
          rsp_q.response_status_code <= RSP_NODATA;
      end
    end
  end
  assign rsp_o = rsp_q;

  // deferred reply issued once target completes; set wins over clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      defer_pend_q <= 1'b0;
      defer_reply_q <= 1'b0;
    end
    else
    begin
      defer_reply_q <= defer_pend_q && defer_done_i;
      if (retire && head.can_defer && defer_en_i &&
          !(head.can_retry && hub_busy_i))
        defer_pend_q <= 1'b1;
      else if (defer_done_i)
        defer_pend_q <= 1'b0;
    end
  end
  assign defer_reply_o = defer_reply_q;

  queue_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cnt <= (PW+1)'(DEPTH)) else $error("queue overflow");
  full_stall_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cnt == (PW+1)'(DEPTH) |-> !req_ready_o)
    else $error("accepted while full");
  order_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    retire |=> rp_q == $past(rp_q) + 1'b1)
    else $error("queue not in order");
  wb_noretry_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    retire && head.dest == DST_DRAM && head.is_write |=>
    rsp_o.response_status_code != RSP_RETRY)
    else $error("dram write retried");
  rsp_legal_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rsp_o.response_status_code != 3'h4 && rsp_o.response_status_code != 3'h3)
    else $error("illegal response code");
  idle_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !retire |=> rsp_o.response_status_code == RSP_IDLE)
    else $error("response not idle");
  data_with_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rsp_o.data_valid == (rsp_o.response_status_code == RSP_DATA))
    else $error("data without normal response");
  write_nodata_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    retire && head.is_write && !hub_busy_i && !defer_en_i && !snoop_hitm_i
    |=> rsp_o.response_status_code == RSP_NODATA)
    else $error("write without no-data response");
  cfg_local_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    push && dec.dest == DST_CFG |-> !dec.can_retry && !dec.can_defer)
    else $error("config access sent out");
endmodule // host_bus_transaction_decoder

// ==== verification/hbd_cpu_model.sv ====
`timescale 1ns/1ns
module hbd_cpu_model
  import hbd_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  input wire logic req_ready_i,
  output logic req_valid_o,
  output host_req_t req_o
);
  host_req_t pend_q[$];

  // phase-two size field is forced to 00 before queueing, phase-one only for codes below RQ_SPECIAL; the length field goes out as given, 11 included
  task automatic send(input host_req_t r);
    r.request_code_phase_two[4:3] = SIZE_OK;
    if (r.request_code_phase_one < RQ_SPECIAL)
      r.request_code_phase_one[4:3] = SIZE_OK;
    pend_q.push_back(r);
  endtask

  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      req_valid_o <= 1'b0;
      req_o <= '0;
    end
    else if (!req_valid_o || req_ready_i)
    begin
      // slow mode leaves one idle cycle after each accepted request
      if (pend_q.size() > 0 && !(slow_i && req_valid_o))
      begin
        req_valid_o <= 1'b1;
        req_o <= pend_q.pop_front();
      end
      else
      begin
        req_valid_o <= 1'b0;
        // released lines wander so a stale value is never trusted
        req_o <= ~req_o;
      end
    end
endmodule // hbd_cpu_model

// ==== verification/host_bus_transaction_decoder_tb.sv ====
`timescale 1ns/1ns
module host_bus_transaction_decoder_tb
  import hbd_pkg::*;
;
  typedef struct {dest_t dst; logic ck, rd, rt, df; logic [1:0] len;} exp_t;
  localparam logic [31:0] TOP = 32'h1000_0000;
  localparam logic [31:0] GB = 32'h2000_0000;
  localparam logic [31:0] GM = 32'hF000_0000;
  logic clk = 0, nrst = 0, rv, rr, dv, dr = 0, wv = 0, wr, busy = 0;
  logic den = 0, hitm = 0, ddone = 0, drep, bad, ten = 0, slow = 0;
  logic pend = 0;
  logic [2:0] pc;
  logic [1:0] ln;
  logic [63:0] wd = '0;
  host_req_t rq;
  txn_t disp;
  host_rsp_t rsp;
  exp_t eq[$], ex;
  logic [63:0] dq[$];
  integer seed = 27, error_cnt = 0, samples_checked = 0, i, k;
  logic [4:0] ca[10] = '{RQ_MEM_RDINV, RQ_MEM_CODE, RQ_MEM_DATA, RQ_IO_RD,
    RQ_SPECIAL, RQ_MEM_WB, RQ_MEM_WR, RQ_IO_WR, RQ_SPECIAL, RQ_BTM};
  logic [4:0] cb[10] = '{5'h00, 5'h00, 5'h00, 5'h00, RQB_INTA, 5'h00,
    5'h00, 5'h00, RQB_SPEC, 5'h00};
  logic [31:0] aa[10] = '{32'h100, 32'h8000_0000, 32'h2000_0100, 32'h60,
    32'h0, 32'h8000_0000, 32'h200, 32'hCF8, 32'h0, 32'h0};

  always #5 clk = ~clk;
  always @(posedge clk) dr <= ten && ($random(seed) & 1);

  hbd_cpu_model u_cpu (.clk_i(clk), .nrst_i(nrst), .slow_i(slow),
    .req_ready_i(rr), .req_valid_o(rv), .req_o(rq));
  host_bus_transaction_decoder u_dut (.clk_i(clk), .nrst_i(nrst),
    .req_valid_i(rv), .req_ready_o(rr), .req_i(rq), .dram_top_i(TOP),
    .gfx_base_i(GB), .gfx_mask_i(GM), .lock_i(1'b0),
    .snoop_hitm_i(hitm), .hub_busy_i(busy), .defer_en_i(den),
    .disp_valid_o(dv), .disp_ready_i(dr), .disp_o(disp),
    .rdata_valid_i(wv), .rdata_ready_o(wr), .rdata_i(wd),
    .defer_done_i(ddone), .defer_reply_o(drep), .rsp_o(rsp),
    .bad_size_o(bad));

  task automatic chk(input string n, input logic [63:0] e, s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic exp_t pred(host_req_t r);
    exp_t x;
    logic [4:0] a;
    a = r.request_code_phase_one;
    x.len = r.request_code_phase_two[1:0];
    x.ck = a != RQ_BTM;
    x.rd = a inside {RQ_MEM_RDINV, RQ_MEM_CODE, RQ_MEM_DATA, RQ_IO_RD} ||
      (a == RQ_SPECIAL && r.request_code_phase_two == RQB_INTA);
    if (a == RQ_MEM_WB)
      x.dst = DST_DRAM;
    else if (a[4])
      x.dst = r.addr[15:0] inside {[IO_CFG_LO:IO_CFG_HI]} ? DST_CFG
        : DST_HUB;
    else if (a[3])
      x.dst = r.request_code_phase_two[0] ? DST_SPEC : DST_HUB;
    else if (r.addr < TOP)
      x.dst = DST_DRAM;
    else
      x.dst = (r.addr & GM) == GB ? DST_GFX : DST_HUB;
    x.rt = x.dst == DST_HUB;
    x.df = (x.dst == DST_HUB && (x.rd || a == RQ_IO_WR)) ||
      (x.dst == DST_GFX && x.rd);
    return x;
  endfunction

  always @(posedge clk)
  begin
    chk("size flag", 0, bad);
    if (pend)
    begin
      chk("rsp code", pc, rsp.response_status_code);
      chk("data flag", pc == RSP_DATA, rsp.data_valid);
      if (pc == RSP_DATA)
        chk("rsp data", dq.pop_front(), rsp.data);
    end
    else
      chk("idle code", RSP_IDLE, rsp.response_status_code);
    pend = 0;
    if (wv && wr)
      dq.push_back(wd);
    if (rv && rr)
      eq.push_back(pred(rq));
    if (dv && dr)
    begin
      ex = eq.pop_front();
      if (ex.ck)
        chk("dest", ex.dst, disp.dest);
      if (ex.ck)
        chk("length", ex.len, disp.transfer_length_field);
      // retry beats defer beats writeback beats data
      pc = busy && ex.rt ? RSP_RETRY : den && ex.df ? RSP_DEFER :
        hitm ? RSP_IWB : ex.rd ? RSP_DATA : RSP_NODATA;
      pend = 1;
    end
  end

  task automatic put(input integer n);
    wv <= 1'b1;
    repeat (n)
    begin
      wd <= {$random(seed), $random(seed)};
      @(negedge clk);
      while (!wr) @(negedge clk);
      @(posedge clk);
    end
    wv <= 1'b0;
  endtask

  task automatic send(input logic [4:0] a, b, input logic [31:0] ad);
    ln = $unsigned($random(seed)) % 3;
    u_cpu.send('{a, a[3] ? b : {3'h0, ln}, ad, 8'hFF});
  endtask

  task automatic fin(input string n);
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while ((u_cpu.pend_q.size() > 0 || rv || eq.size() > 0 || pend) &&
      i < 3000);
    chk("drain", 1, i < 3000);
    $display("test %s done", n);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    ten <= 1'b1;
    put(5);
    for (k = 0; k < 10; k++)
      send(ca[k], cb[k], aa[k]);
    fin("codes");
    ten <= 1'b0;
    for (k = 0; k < 6; k++)
      send(RQ_IO_WR, 5'h00, 32'h80);
    repeat (12) @(negedge clk);
    chk("req ready", 0, rr);
    chk("queued", 4, eq.size());
    ten <= 1'b1;
    fin("queue");
    busy <= 1'b1;
    send(RQ_IO_WR, 5'h00, 32'h80);
    send(RQ_MEM_WB, 5'h00, 32'h8000_0000);
    fin("retry");
    busy <= 1'b0;
    den <= 1'b1;
    send(RQ_IO_WR, 5'h00, 32'h80);
    fin("defer");
    den <= 1'b0;
    ddone <= 1'b1;
    @(posedge clk);
    ddone <= 1'b0;
    k = 0;
    repeat (4)
    begin
      @(negedge clk);
      k = k | drep;
    end
    chk("defer reply", 1, k);
    @(posedge clk);
    hitm <= 1'b1;
    send(RQ_MEM_WR, 5'h00, 32'h300);
    fin("writeback");
    hitm <= 1'b0;
    ten <= 1'b0;
    put(32);
    @(negedge clk);
    chk("buffer full", 0, wr);
    @(posedge clk);
    slow <= 1'b1;
    ten <= 1'b1;
    for (k = 0; k < 32; k++)
      send(RQ_MEM_DATA, 5'h00, $random(seed) & 32'h0FFF_FFF8);
    fin("buffer");
    results;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results;
  end
endmodule // host_bus_transaction_decoder_tb
